// >>> logic/pcrc_pkg.sv
// Shared constants for the programmable CRC engine and its bus-side controller.
// Assumes both ends run on one clock with a synchronous active-high reset.
package pcrc_pkg;

    // --------------------------------------------------------------------
    // Engine register offsets (byte addresses on the link)
    // --------------------------------------------------------------------
    localparam logic [3:0] PCRC_DATA_OFS = 4'h0;
    localparam logic [3:0] PCRC_POLY_OFS = 4'h4;
    localparam logic [3:0] PCRC_CTRL_OFS = 4'h8;

    // --------------------------------------------------------------------
    // Control register fields
    // --------------------------------------------------------------------
    localparam int PCRC_WTP_LO = 30;
    localparam int PCRC_RTP_LO = 28;
    localparam int PCRC_CPL_BIT = 26;
    localparam int PCRC_WAS_BIT = 25;
    localparam int PCRC_WIDE_BIT = 24;
    localparam logic [31:0] PCRC_CTRL_MASK = 32'hf700_0000;

    // Transpose codes
    localparam logic [1:0] PCRC_TP_NONE = 2'h0;
    localparam logic [1:0] PCRC_TP_BITS = 2'h1;
    localparam logic [1:0] PCRC_TP_ALL = 2'h2;
    localparam logic [1:0] PCRC_TP_BYTES = 2'h3;

    // --------------------------------------------------------------------
    // Reset values and widths
    // --------------------------------------------------------------------
    localparam logic [31:0] PCRC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PCRC_POLY_RST = 32'h0000_1021;
    localparam logic [31:0] PCRC_DATA_RST = 32'hffff_ffff;
    localparam logic [31:0] PCRC_LOW_MASK = 32'h0000_ffff;
    localparam int PCRC_BITS_PER_CYC = 4;
    localparam int PCRC_CYC_PER_BYTE = 2;

    // --------------------------------------------------------------------
    // Controller registers on AXI4-Lite
    // --------------------------------------------------------------------
    localparam logic [3:0] PCRC_H_CMD_OFS = 4'h0;
    localparam logic [3:0] PCRC_H_ARG_OFS = 4'h4;
    localparam logic [3:0] PCRC_H_STAT_OFS = 4'h8;
    localparam logic [3:0] PCRC_H_RES_OFS = 4'hc;
    localparam int PCRC_CMD_WE_BIT = 0;
    localparam int PCRC_CMD_ADDR_LO = 4;
    localparam int PCRC_CMD_BE_LO = 8;
    localparam int PCRC_STAT_BUSY_BIT = 0;
    localparam int PCRC_STAT_DONE_BIT = 1;
    localparam int PCRC_STAT_ERR_BIT = 2;
    localparam logic [1:0] PCRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCRC_RESP_SLVERR = 2'h2;

endpackage : pcrc_pkg

// >>> logic/pcrc_if.sv
// Register link between the CRC engine and the controller that drives it.
// Assumes one shared clock; a request is held until the one-cycle ack.
`timescale 1ns/10ps
interface pcrc_if;
    logic req;
    logic we;
    logic [3:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;

    modport dev (input req, input we, input addr, input be, input wdata,
                 output ack, output rdata);
    modport host (output req, output we, output addr, output be, output wdata,
                  input ack, input rdata);
endinterface : pcrc_if

// >>> logic/pcrc_dev.sv
// Programmable CRC engine: control, polynomial and data registers behind the link.
// Assumes the controller holds req and its payload until ack, on the same clock.
//
// Notes on behaviour
// - Data writes of 8, 16, 24 or 32 bits.
// - Host keeps written bytes contiguous.
// - Seed-load set: data write becomes seed.
// - Reseed any time by setting seed-load again.
// - Host configures everything before seed and data.
// - Host clears seed-load before data writes.
// - Width clear: 16-bit mode, low polynomial half.
// - 16-bit seed and result in low bytes.
// - Every data write updates stored checksum.
// - Width set: full 32-bit polynomial and result.
// - Bytewise update, two clocks per byte.
// - Separate write and read transpose fields.
// - Code 00 unchanged; 01 reverses bits per byte.
// - Code 10 reverses all 32 bits.
// - Code 11 swaps byte order only.
// - Short writes transposed with zeros, valid bytes only.
// - 16-bit result lands high under read 10/11.
// - Host should read the checksum as 32 bits.
// - Complement-on-read inverts every data read.
// - Polynomial high half writable only in 32-bit mode.
`timescale 1ns/10ps
module pcrc_dev
    import pcrc_pkg::*;
#(
    parameter logic [31:0] DATA_RST = PCRC_DATA_RST
) (
    input wire logic i_clk,
    input wire logic i_rst,
    pcrc_if.dev bus,
    output logic o_busy
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] pcrc_swap(input logic [31:0] v);
        pcrc_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : pcrc_swap

    function automatic logic [31:0] pcrc_tpose(input logic [31:0] v, input logic [1:0] c);
        logic [31:0] rev;
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            rev[i] = v[31 - i];
        end
        case (c)
            PCRC_TP_BITS: r = pcrc_swap(rev);
            PCRC_TP_ALL: r = rev;
            PCRC_TP_BYTES: r = pcrc_swap(v);
            default: r = v;
        endcase
        pcrc_tpose = r;
    endfunction : pcrc_tpose

    // Lane mask follows the bytes when transposition moves them
    function automatic logic [3:0] pcrc_tmask(input logic [3:0] be, input logic [1:0] c);
        pcrc_tmask = c[1] ? {be[0], be[1], be[2], be[3]} : be;
    endfunction : pcrc_tmask

    function automatic logic [31:0] pcrc_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        pcrc_merge = r;
    endfunction : pcrc_merge

    // Four polynomial-division shifts, in the width the mode selects
    function automatic logic [31:0] pcrc_step(input logic [31:0] v, input logic [31:0] p,
                                              input logic wide);
        logic [31:0] r;
        logic msb;
        r = v;
        for (int i = 0; i < PCRC_BITS_PER_CYC; i++) begin
            if (wide) begin
                msb = r[31];
                r = {r[30:0], 1'b0};
                if (msb) begin
                    r = r ^ p;
                end
            end else begin
                msb = r[15];
                r = {16'h0000, r[14:0], 1'b0};
                if (msb) begin
                    r = r ^ (p & PCRC_LOW_MASK);
                end
            end
        end
        pcrc_step = r;
    endfunction : pcrc_step

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] poly_q;
    logic [31:0] crc_q;
    logic [31:0] din_q;
    logic [3:0] pend_q;
    logic [3:0] pend_d;
    logic phase_q;
    logic busy_q;
    logic ack_q;
    logic [31:0] rdata_q;

    logic wide;
    logic [1:0] wtp;
    logic [1:0] rtp;
    logic hit_data;
    logic take;
    logic wr;
    logic [31:0] wmask;
    logic [31:0] wt;
    logic [3:0] bt;
    logic [1:0] sel;
    logic [7:0] cur_byte;
    logic [31:0] width_mask;

    assign wide = ctrl_q[PCRC_WIDE_BIT];
    assign wtp = ctrl_q[PCRC_WTP_LO +: 2];
    assign rtp = ctrl_q[PCRC_RTP_LO +: 2];
    assign width_mask = wide ? 32'hffff_ffff : PCRC_LOW_MASK;
    assign hit_data = (bus.addr == PCRC_DATA_OFS);
    // Only the data register waits; config writes mid-update are the host's risk
    assign take = bus.req && !ack_q && !(hit_data && busy_q);
    assign wr = take && bus.we;

    always_comb begin
        wmask = '0;
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = {8{bus.be[i]}};
        end
    end

    // Unused lanes enter the transpose as zeros
    assign wt = pcrc_tpose(bus.wdata & wmask, wtp);
    assign bt = pcrc_tmask(bus.be, wtp);

    // Highest pending lane goes first, matching a 32-bit write's byte order
    always_comb begin
        sel = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (pend_q[i]) begin
                sel = 2'(i);
            end
        end
    end
    assign cur_byte = din_q[8*sel +: 8];

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q <= PCRC_CTRL_RST;
        end else if (wr && bus.addr == PCRC_CTRL_OFS) begin
            ctrl_q <= pcrc_merge(ctrl_q, bus.wdata, bus.be) & PCRC_CTRL_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            poly_q <= PCRC_POLY_RST;
        end else if (wr && bus.addr == PCRC_POLY_OFS) begin
            poly_q <= pcrc_merge(poly_q, bus.wdata,
                                 wide ? bus.be : {2'b00, bus.be[1:0]});
        end
    end

    // ------------------------------------------------------------------
    // Bytewise engine
    // ------------------------------------------------------------------
    always_comb begin
        pend_d = pend_q;
        if (wr && hit_data && !ctrl_q[PCRC_WAS_BIT]) begin
            pend_d = bt;
        end else if (busy_q && phase_q) begin
            pend_d[sel] = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_q <= 4'h0;
            busy_q <= 1'b0;
            phase_q <= 1'b0;
            din_q <= 32'h0000_0000;
        end else begin
            pend_q <= pend_d;
            busy_q <= |pend_d;
            if (wr && hit_data) begin
                din_q <= wt;
                phase_q <= 1'b0;
            end else if (busy_q) begin
                phase_q <= !phase_q;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            crc_q <= DATA_RST;
        end else if (wr && hit_data && ctrl_q[PCRC_WAS_BIT]) begin
            // High bytes are dropped in 16-bit mode
            crc_q <= pcrc_merge(crc_q, wt, bt) & width_mask;
        end else if (busy_q && !phase_q) begin
            // First clock folds the byte in and does four shifts
            crc_q <= pcrc_step(crc_q ^ (wide ? {cur_byte, 24'h0} : {16'h0, cur_byte, 8'h0}),
                               poly_q, wide);
        end else if (busy_q) begin
            crc_q <= pcrc_step(crc_q, poly_q, wide);
        end
    end

    // ------------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= take;
            if (take && !bus.we) begin
                case (bus.addr)
                    PCRC_DATA_OFS: rdata_q <= pcrc_tpose((crc_q & width_mask) ^
                        (ctrl_q[PCRC_CPL_BIT] ? width_mask : 32'h0000_0000),
                        rtp);
                    PCRC_POLY_OFS: rdata_q <= wide ? poly_q : (poly_q & PCRC_LOW_MASK);
                    PCRC_CTRL_OFS: rdata_q <= ctrl_q;
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign o_busy = busy_q;

endmodule : pcrc_dev

// >>> logic/pcrc_host.sv
// Controller end: takes orders over AXI4-Lite and drives the CRC engine link.
// Assumes the engine answers each held request with a one-cycle ack.
`timescale 1ns/10ps
module pcrc_host
    import pcrc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [3:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [3:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    pcrc_if.host bus
);

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] arg_q, res_q;
    logic req_q, we_q, done_q, err_q;
    logic [3:0] addr_q, be_q;
    logic do_wr, cmd_wr, cmd_we, contig;
    logic [3:0] cmd_be;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign do_wr = !awready_q && !wready_q && !bvalid_q;
    assign cmd_wr = do_wr && awaddr_q == PCRC_H_CMD_OFS;
    assign cmd_we = wdata_q[PCRC_CMD_WE_BIT];
    // Reads always take the full word so transposed 16-bit results are seen
    assign cmd_be = cmd_we ? wdata_q[PCRC_CMD_BE_LO +: 4] : 4'hf;

    always_comb begin
        case (cmd_be)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf: contig = 1'b1;
            default: contig = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= PCRC_RESP_OKAY;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (i_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == PCRC_H_CMD_OFS || awaddr_q == PCRC_H_ARG_OFS) ?
                           PCRC_RESP_OKAY : PCRC_RESP_SLVERR;
            end else if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arg_q <= 32'h0000_0000;
        end else if (do_wr && awaddr_q == PCRC_H_ARG_OFS) begin
            for (int i = 0; i < 4; i++) begin
                if (wstrb_q[i]) begin
                    arg_q[8*i +: 8] <= wdata_q[8*i +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Link requests, issued strictly in the order software gives them
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 4'h0;
            be_q <= 4'h0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            res_q <= 32'h0000_0000;
        end else if (cmd_wr && req_q) begin
            err_q <= 1'b1;
        end else if (cmd_wr && cmd_we && !contig) begin
            err_q <= 1'b1;
        end else if (cmd_wr) begin
            req_q <= 1'b1;
            we_q <= cmd_we;
            addr_q <= wdata_q[PCRC_CMD_ADDR_LO +: 4];
            be_q <= cmd_be;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else if (req_q && bus.ack) begin
            req_q <= 1'b0;
            done_q <= 1'b1;
            if (!we_q) begin
                res_q <= bus.rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PCRC_RESP_OKAY;
        end else if (i_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= PCRC_RESP_OKAY;
            case (i_araddr)
                PCRC_H_ARG_OFS: rdata_q <= arg_q;
                PCRC_H_STAT_OFS: rdata_q <= {29'h0, err_q, done_q, req_q};
                PCRC_H_RES_OFS: rdata_q <= res_q;
                PCRC_H_CMD_OFS: rdata_q <= {20'h0, be_q, addr_q, 3'h0, we_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= PCRC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign bus.req = req_q;
    assign bus.we = we_q;
    assign bus.addr = addr_q;
    assign bus.be = be_q;
    assign bus.wdata = arg_q;

endmodule : pcrc_host

// >>> dv/pcrc_link_props.sv
// Assertions on the link that joins the CRC engine to its controller.
// Assumes the bench feeds the link inputs from the one shared link interface and i_busy from the engine's o_busy.
`timescale 1ns/10ps
module pcrc_link_props
    import pcrc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [3:0] i_addr,
    input wire logic [3:0] i_be,
    input wire logic [31:0] i_wdata,
    input wire logic i_ack,
    input wire logic [31:0] i_rdata,
    input wire logic i_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ----------------------------------------------------------------
    // Link handshake and update timing
    // ----------------------------------------------------------------
    a_ack_one_pulse: assert property (i_ack |=> !i_ack)
        else $error("ack longer than one cycle");
    a_ack_drops_req: assert property (i_ack |-> i_req ##1 !i_req)
        else $error("ack without held request");
    a_req_held: assert property (i_req && !i_ack
        |=> i_req && $stable({i_we, i_addr, i_be, i_wdata}))
        else $error("request changed before ack");
    a_other_no_wait: assert property (i_req && !i_ack && i_addr != PCRC_DATA_OFS
        |-> ##[1:3] i_ack)
        else $error("non-data access delayed");
    a_data_waits: assert property (i_ack && i_addr == PCRC_DATA_OFS
        |-> !$past(i_busy))
        else $error("data access acked during update");
    a_data_bounded: assert property (i_req && !i_ack && i_addr == PCRC_DATA_OFS
        |-> ##[1:20] i_ack)
        else $error("data access never acked");
    a_word_eight: assert property (i_ack && i_we && i_be == 4'hf && i_busy
        |=> i_busy[*7] ##1 !i_busy)
        else $error("word update not eight cycles");
    a_half_four: assert property (i_ack && i_we && i_be == 4'h3 && i_busy
        |=> i_busy[*3] ##1 !i_busy)
        else $error("halfword update not four cycles");
    a_byte_two: assert property (i_ack && i_we && i_be == 4'h1 && i_busy
        |=> i_busy ##1 !i_busy)
        else $error("byte update not two cycles");
    a_busy_cause: assert property ($rose(i_busy)
        |-> i_ack && i_we && i_addr == PCRC_DATA_OFS)
        else $error("update started without data write");
    a_rdata_on_read: assert property (!$stable(i_rdata) |-> i_ack && !i_we)
        else $error("read data moved without read");

    c_stall: cover property (i_req && i_addr == PCRC_DATA_OFS && i_busy);
    c_word: cover property (i_ack && i_we && i_be == 4'hf && i_busy);
    c_read: cover property (i_ack && !i_we);
endmodule : pcrc_link_props

// >>> dv/programmable_crc_engine_test.sv
// Self-checking bench: AXI4-Lite orders into the controller, engine behind the link.
// Assumes the controller map CMD/ARG/STAT/RES and one 100 MHz clock.
`timescale 1ns/10ps
module programmable_crc_engine_test
    import pcrc_pkg::*;
;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, busy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_count = 0;
    int cmp_count = 0;

    pcrc_if pcrc_if_i ();
    pcrc_dev pcrc_dev_i (.i_clk(i_clk), .i_rst(i_rst), .bus(pcrc_if_i.dev), .o_busy(busy));
    pcrc_host pcrc_host_i (.i_clk(i_clk), .i_rst(i_rst), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .bus(pcrc_if_i.host));
    pcrc_link_props pcrc_link_props_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(pcrc_if_i.req),
        .i_we(pcrc_if_i.we), .i_addr(pcrc_if_i.addr), .i_be(pcrc_if_i.be),
        .i_wdata(pcrc_if_i.wdata), .i_ack(pcrc_if_i.ack), .i_rdata(pcrc_if_i.rdata),
        .i_busy(busy));

    always #5 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Bus tasks and reference model
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        bready <= 1'h1;
        do begin
            @(posedge i_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(posedge i_clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        chk("rresp", 32'h0, {30'h0, rresp});
    endtask : axi_rd

    // Polls status so no new order lands while one is outstanding
    task automatic link_go(input logic w, input logic [3:0] a, input logic [3:0] b);
        logic [31:0] s;
        axi_wr(PCRC_H_CMD_OFS, {20'h0, b, a, 3'h0, w}, PCRC_RESP_OKAY);
        for (int k = 0; k < 50; k++) begin
            axi_rd(PCRC_H_STAT_OFS, s);
            if (!s[PCRC_STAT_BUSY_BIT]) break;
        end
        chk("stat", 32'h2, s & 32'h7);
    endtask : link_go

    task automatic link_wr(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
        axi_wr(PCRC_H_ARG_OFS, d, PCRC_RESP_OKAY);
        link_go(1'h1, a, b);
    endtask : link_wr

    task automatic link_rd(input logic [3:0] a, output logic [31:0] d);
        link_go(1'h0, a, 4'hf);
        axi_rd(PCRC_H_RES_OFS, d);
    endtask : link_rd

    function automatic logic [31:0] tp(input logic [31:0] v, input logic [1:0] c);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) r[i] = v[31-i];
        case (c)
            2'h0: return v;
            2'h1: return {r[7:0], r[15:8], r[23:16], r[31:24]};
            2'h2: return r;
            default: return {v[7:0], v[15:8], v[23:16], v[31:24]};
        endcase
    endfunction : tp

    // Bytewise MSB-first fold; lane mask travels with the data
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d,
        input logic [3:0] b, input logic [1:0] wc, input logic w, input logic [31:0] p);
        logic [31:0] m, t;
        logic top;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        t = tp(d & m, wc);
        m = tp(m, wc);
        for (int l = 3; l >= 0; l--) begin
            if (m[8*l]) begin
                c = w ? c ^ {t[8*l+:8], 24'h0} : c ^ {16'h0, t[8*l+:8], 8'h0};
                for (int i = 0; i < 8; i++) begin
                    top = w ? c[31] : c[15];
                    c = (c << 1) ^ (top ? p : 32'h0);
                end
                if (!w) c = c & PCRC_LOW_MASK;
            end
        end
        return c;
    endfunction : fold

    function automatic logic [31:0] rexp(input logic [31:0] c, input logic w, input logic fx,
        input logic [1:0] code);
        logic [31:0] v;
        v = w ? c : (c & PCRC_LOW_MASK);
        if (fx) v = v ^ (w ? 32'hffff_ffff : PCRC_LOW_MASK);
        return tp(v, code);
    endfunction : rexp

    function automatic logic [31:0] ctl(input logic [1:0] c, input logic fx, input logic s,
        input logic w);
        return {c, c, 1'h0, fx, s, w, 24'h0};
    endfunction : ctl

    task close_out;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        close_out;
    end

    initial begin
        logic [31:0] got, crc, pw;
        logic w, fx;
        logic [1:0] code;
        logic [3:0] bes [3];
        logic [31:0] dats [3];
        bes = '{4'hf, 4'h3, 4'h1};
        // Junk in the upper bytes of short writes must be ignored
        dats = '{32'h3132_3334, 32'hdead_3536, 32'hbeef_ff37};
        repeat (12) @(posedge i_clk);
        i_rst <= 1'h0;
        link_rd(PCRC_DATA_OFS, got);
        chk("data_rst", PCRC_DATA_RST & PCRC_LOW_MASK, got);
        link_rd(PCRC_POLY_OFS, got);
        chk("poly_rst", PCRC_POLY_RST, got);
        link_rd(PCRC_CTRL_OFS, got);
        chk("ctrl_rst", PCRC_CTRL_RST, got);
        link_wr(PCRC_POLY_OFS, 4'hf, 32'h1234_8005);
        link_rd(PCRC_POLY_OFS, got);
        chk("poly16", 32'h0000_8005, got);
        for (int i = 0; i < 8; i++) begin
            w = i[2];
            code = i[1:0];
            fx = i[0] ^ i[2];
            pw = w ? 32'h04c1_1db7 : 32'h0000_1db7;
            link_wr(PCRC_CTRL_OFS, 4'hf, ctl(code, fx, 1'h1, w));
            // Read first: the first wide pass still holds a clear high half
            link_rd(PCRC_POLY_OFS, got);
            chk("poly", i == 0 ? 32'h8005 : i > 4 ? pw : 32'h1db7, got);
            link_wr(PCRC_POLY_OFS, 4'hf, 32'h04c1_1db7);
            link_wr(PCRC_DATA_OFS, 4'hf, 32'hffff_ffff);
            crc = w ? 32'hffff_ffff : 32'h0000_ffff;
            link_rd(PCRC_DATA_OFS, got);
            chk("seed", rexp(crc, w, fx, code), got);
            link_wr(PCRC_CTRL_OFS, 4'hf, ctl(code, fx, 1'h0, w));
            link_rd(PCRC_CTRL_OFS, got);
            chk("ctrl", ctl(code, fx, 1'h0, w), got);
            for (int k = 0; k < 3; k++) begin
                link_wr(PCRC_DATA_OFS, bes[k], dats[k]);
                crc = fold(crc, dats[k], bes[k], code, w, pw);
            end
            link_rd(PCRC_DATA_OFS, got);
            chk("crc", rexp(crc, w, fx, code), got);
        end
        axi_wr(PCRC_H_CMD_OFS, {20'h0, 4'h5, PCRC_DATA_OFS, 4'h1}, PCRC_RESP_OKAY);
        axi_rd(PCRC_H_STAT_OFS, got);
        chk("gap_err", 32'h1, {31'h0, got[PCRC_STAT_ERR_BIT]});
        // Word write then read at once, so the read stalls on the update
        link_wr(PCRC_DATA_OFS, 4'hf, dats[0]);
        crc = fold(crc, dats[0], 4'hf, code, w, pw);
        link_rd(PCRC_DATA_OFS, got);
        chk("crc_kept", rexp(crc, 1'h1, 1'h0, 2'h3), got);
        axi_wr(PCRC_H_STAT_OFS, 32'h0, PCRC_RESP_SLVERR);
        link_rd(4'hc, got);
        chk("unmapped", 32'h0, got);
        close_out;
    end
endmodule : programmable_crc_engine_test
